// >>> rtc_ctrl_defines.vh
// Register offsets, field positions, reset values and timing counts for the clock block
`ifndef RTC_CTRL_DEFINES_VH
`define RTC_CTRL_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_SECONDS_COUNT     4'h0
`define OFS_CLOCK_CTRL_ONE    4'h1
`define OFS_PERIODIC_IRQ_EN   4'h2
`define OFS_CLOCK_SRC_SEL     4'h3
`define OFS_IRQ_FLAG          4'h4
`define OFS_STATUS            4'h5

// ****************************************
// Field positions
// ****************************************
`define BIT_RUN               7
`define BIT_OVF_EN            5
`define BIT_WEEK_EN           4
`define BIT_DAY_EN            3
`define BIT_HOUR_EN           2
`define BIT_MIN_EN            1
`define BIT_SEC_EN            0
`define BIT_BUSY              7
`define BIT_CLOCK_IRQ         0

// ****************************************
// Reset values
// ****************************************
`define RST_SRC_SEL           4'h8
`define RST_CLKOUT_SEL        2'h0
`define RST_IRQ_EN            6'h00

// ****************************************
// Timing
// ****************************************
`define BUSY_TIME_US          62500
`define CLK_PERIOD_NS         10
`define BUSY_CYCLES           ((`BUSY_TIME_US * 1000) / `CLK_PERIOD_NS)

`endif

// >>> rtc_ctrl.v
// Clock block: interrupt control, source select, free-running counter and clock output
// How it works
// - Enabled calendar events set shared interrupt flag
// - Enable bits 5..0, bits 7,6 read zero
// - Non-calendar source gives 8-bit free counter
// - Source codes 0xxx divide, 1xxx calendar
// - Run bit starts and stops counter
// - Seconds register reads counter in counter mode
// - Enabled counter overflow raises interrupt
// - Output select picks divide by 4/8/16
// - Clock output only in active/sleep mode
// - Time registers ignore external reset
// - Busy held during update, ~62.5 ms
// - Writing zero clears interrupt flag
// - Week event when day-of-week becomes zero
// - Day/hour/minute/second event on count advance
// - Source resets to 1000, rest zero
// - Run bit zero stops, one starts
// - Busy reads one while updating time
`timescale 1ns/10ps
`include "rtc_ctrl_defines.vh"

module rtc_ctrl
#(
	parameter integer BUSY_CYCLES = `BUSY_CYCLES
)
(
	// Clock, reset, enable
	input  wire       clk_i,
	input  wire       rst_n_i,
	input  wire       clk_en_i,
	// Register port
	input  wire [3:0] addr_i,
	input  wire [7:0] wdata_i,
	input  wire       wr_i,
	input  wire       rd_i,
	output reg  [7:0] rdata_o,
	// Calendar interface
	input  wire       tick_32k_i,
	input  wire       sec_adv_i,
	input  wire       min_adv_i,
	input  wire       hour_adv_i,
	input  wire       day_adv_i,
	input  wire [2:0] day_of_week_i,
	input  wire [7:0] cal_seconds_i,
	input  wire       update_start_i,
	output wire       calendar_en_o,
	output wire       run_o,
	// Chip mode and pin
	input  wire       active_or_sleep_i,
	input  wire       clock_out_pin_en_i,
	output reg        clock_out_pin_o,
	output wire       clock_out_pin_oe_o,
	// Interrupt flag
	output wire       clock_irq_flag_o
);

	// ****************************************
	// Control registers
	// ****************************************
	reg        run_q;
	reg  [5:0] irq_en_q;
	reg  [3:0] src_sel_q;
	reg  [1:0] clkout_sel_q;
	reg        irq_q;
	reg        busy_q;
	reg [31:0] busy_cnt_q;
	reg  [7:0] frc_q;
	reg [12:0] div_q;
	reg  [2:0] dow_q;
	reg        dow_valid_q;
	reg        clk_div_q;
	reg        frc_tick;
	reg        clk_sel;
	wire       cal_mode;
	wire       frc_ovf;
	wire       cal_event;
	wire       irq_set;
	wire       week_event;
	wire [7:0] ctrl_rd;
	wire [7:0] en_rd;
	wire [7:0] src_rd;

	assign cal_mode      = src_sel_q[3];
	assign calendar_en_o = cal_mode & run_q;
	assign run_o         = run_q;

	// ****************************************
	// Register writes
	// ****************************************
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			run_q        <= 1'b0;
			irq_en_q     <= `RST_IRQ_EN;
			src_sel_q    <= `RST_SRC_SEL;
			clkout_sel_q <= `RST_CLKOUT_SEL;
		end
		else if (clk_en_i && wr_i)
		begin
			case (addr_i)
				`OFS_CLOCK_CTRL_ONE:  run_q <= wdata_i[`BIT_RUN];
				`OFS_PERIODIC_IRQ_EN: irq_en_q <= wdata_i[5:0];
				`OFS_CLOCK_SRC_SEL:
				begin
					src_sel_q    <= wdata_i[3:0];
					clkout_sel_q <= wdata_i[6:5];
				end
				default: run_q <= run_q;
			endcase
		end
	end

	// ****************************************
	// Prescaler and free-running counter
	// ****************************************
	always @*
	begin
		case (src_sel_q[2:0])
			3'h0:    frc_tick = (div_q[2:0] == 3'h7);
			3'h1:    frc_tick = (div_q[4:0] == 5'h1f);
			3'h2:    frc_tick = (div_q[6:0] == 7'h7f);
			3'h3:    frc_tick = (div_q[7:0] == 8'hff);
			3'h4:    frc_tick = (div_q[8:0] == 9'h1ff);
			3'h5:    frc_tick = (div_q[10:0] == 11'h7ff);
			3'h6:    frc_tick = (div_q[11:0] == 12'hfff);
			default: frc_tick = (div_q == 13'h1fff);
		endcase
	end

	assign frc_ovf = ~cal_mode & run_q & frc_tick & (frc_q == 8'hff);

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			div_q <= 13'h0000;
			frc_q <= 8'h00;
		end
		else if (clk_en_i)
		begin
			div_q <= div_q + 13'h0001;
			if (!cal_mode && run_q && frc_tick)
				frc_q <= frc_q + 8'h01;
		end
	end

	// ****************************************
	// Week event: day-of-week becomes zero
	// ****************************************
	// Time registers live outside and never see this reset
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			dow_q       <= 3'h0;
			dow_valid_q <= 1'b0;
		end
		else if (clk_en_i)
		begin
			dow_q       <= day_of_week_i;
			dow_valid_q <= 1'b1;
		end
	end

	assign week_event = dow_valid_q & (dow_q != 3'h0) & (day_of_week_i == 3'h0);

	// ****************************************
	// Interrupt flag
	// ****************************************
	// Event sources line up with enable bits 4..0
	wire [4:0] evt_src;
	wire [4:0] evt_hit;

	assign evt_src = {week_event, day_adv_i, hour_adv_i, min_adv_i, sec_adv_i};

	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1)
		begin : g_evt
			assign evt_hit[g] = irq_en_q[g] & evt_src[g];
		end
	endgenerate

	// One shared flag; the source is lost, so software enables one at a time
	assign cal_event = cal_mode & (|evt_hit);
	assign irq_set = cal_event | (irq_en_q[`BIT_OVF_EN] & frc_ovf);

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			irq_q <= 1'b0;
		else if (clk_en_i)
		begin
			// Set wins over a same-cycle clear
			if (irq_set)
				irq_q <= 1'b1;
			else if (wr_i && addr_i == `OFS_IRQ_FLAG && !wdata_i[`BIT_CLOCK_IRQ])
				irq_q <= 1'b0;
		end
	end

	assign clock_irq_flag_o = irq_q;

	// ****************************************
	// Busy flag
	// ****************************************
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			busy_q     <= 1'b0;
			busy_cnt_q <= 32'h0000_0000;
		end
		else if (clk_en_i)
		begin
			if (!busy_q && update_start_i && cal_mode && run_q)
			begin
				busy_q     <= 1'b1;
				busy_cnt_q <= 32'h0000_0000;
			end
			else if (busy_q)
			begin
				if (busy_cnt_q >= BUSY_CYCLES - 1)
					busy_q <= 1'b0;
				busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
			end
		end
	end

	// ****************************************
	// Clock output divider
	// ****************************************
	always @*
	begin
		case (clkout_sel_q)
			2'h0:    clk_sel = div_q[1];
			2'h1:    clk_sel = div_q[2];
			2'h2:    clk_sel = div_q[3];
			default: clk_sel = 1'b0;
		endcase
	end

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			clk_div_q <= 1'b0;
		else if (clk_en_i)
			clk_div_q <= clk_sel;
	end

	always @*
	begin
		clock_out_pin_o = clk_div_q & active_or_sleep_i & clock_out_pin_en_i;
	end

	assign clock_out_pin_oe_o = clock_out_pin_en_i;

	// ****************************************
	// Register reads
	// ****************************************
	assign ctrl_rd = {run_q, 7'h00};
	assign en_rd   = {2'h0, irq_en_q};
	assign src_rd  = {1'b0, clkout_sel_q, 1'b0, src_sel_q};

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_o <= 8'h00;
		else if (clk_en_i)
		begin
			if (rd_i)
			begin
				case (addr_i)
					`OFS_SECONDS_COUNT:   rdata_o <= cal_mode ? cal_seconds_i : frc_q;
					`OFS_CLOCK_CTRL_ONE:  rdata_o <= ctrl_rd;
					`OFS_PERIODIC_IRQ_EN: rdata_o <= en_rd;
					`OFS_CLOCK_SRC_SEL:   rdata_o <= src_rd;
					`OFS_IRQ_FLAG:        rdata_o <= {7'h00, irq_q};
					`OFS_STATUS:          rdata_o <= {busy_q, 7'h00};
					default:              rdata_o <= 8'h00;
				endcase
			end
			else
				rdata_o <= 8'h00;
		end
	end

endmodule

// >>> rtc_ctrl_props.sv
// Port-level assertions for the clock block
`timescale 1ns/10ps
module rtc_ctrl_props (
	input wire       clk_i, rst_n_i, clk_en_i, wr_i, rd_i,
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i, rdata_o, cal_seconds_i,
	input wire       sec_adv_i, min_adv_i, hour_adv_i, day_adv_i,
	input wire       calendar_en_o, run_o, clock_irq_flag_o,
	input wire       active_or_sleep_i, clock_out_pin_en_i,
	input wire       clock_out_pin_o, clock_out_pin_oe_o
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Any calendar event may legally set the flag
	wire adv = sec_adv_i | min_adv_i | hour_adv_i | day_adv_i;
	rd_idle_a: assert property (clk_en_i && !rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
	rsv_bits_a: assert property (clk_en_i && rd_i && addr_i == 4'h2 |=> rdata_o[7:6] == 2'b00)
		else $error("reserved enable bits set");
	src_mode_a: assert property (clk_en_i && wr_i && addr_i == 4'h3
		|=> calendar_en_o == ($past(wdata_i[3]) && run_o)) else $error("source mode wrong");
	run_bit_a: assert property (clk_en_i && wr_i && addr_i == 4'h1 |=> run_o == $past(wdata_i[7]))
		else $error("run bit wrong");
	cal_read_a: assert property (clk_en_i && rd_i && addr_i == 4'h0 && calendar_en_o
		|=> rdata_o == $past(cal_seconds_i)) else $error("seconds read wrong");
	flag_hold_a: assert property (clock_irq_flag_o && !(clk_en_i && wr_i && addr_i == 4'h4)
		|=> clock_irq_flag_o) else $error("flag dropped");
	flag_clr_a: assert property (clk_en_i && wr_i && addr_i == 4'h4 && !wdata_i[0] && !run_o && !adv
		|=> !clock_irq_flag_o) else $error("flag not cleared");
	pin_gate_a: assert property (!(active_or_sleep_i && clock_out_pin_en_i) |-> !clock_out_pin_o)
		else $error("pin driven while gated");
	pin_oe_a: assert property (clock_out_pin_oe_o == clock_out_pin_en_i) else $error("pin enable wrong");
	freeze_a: assert property (!clk_en_i |=> $stable(rdata_o) && $stable(clock_irq_flag_o))
		else $error("state moved while frozen");
	cover property (clk_en_i && rd_i);
	cover property ($rose(clock_irq_flag_o));
	cover property ($rose(calendar_en_o));
endmodule

bind rtc_ctrl rtc_ctrl_props u_rtc_ctrl_props (.*);

// >>> testbench.sv
// Self-checking bench for the clock block
`timescale 1ns/10ps
module testbench;
	reg        clk_i = 0, rst_n_i = 0, ce = 1, wr_i = 0, rd_i = 0, upd = 0, aos = 1, pen = 1, rd_q = 0, pin_p = 0;
	reg  [3:0] addr_i = 0, adv = 0;
	reg  [7:0] wdata_i = 0, cal_s = 0;
	reg  [2:0] dow = 3;
	reg  [7:0] exp_q[$];
	wire [7:0] rdata;
	wire       cal_en, run, pin, pin_oe, flag;
	integer    failures = 0, n_compared = 0, seed = 32'hcb0f, i, n, p;
	always #5 clk_i = ~clk_i;
	rtc_ctrl #(.BUSY_CYCLES(20)) u_rtc_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(ce),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .tick_32k_i(1'b0),
		.sec_adv_i(adv[0]), .min_adv_i(adv[1]), .hour_adv_i(adv[2]), .day_adv_i(adv[3]),
		.day_of_week_i(dow), .cal_seconds_i(cal_s), .update_start_i(upd), .calendar_en_o(cal_en),
		.run_o(run), .active_or_sleep_i(aos), .clock_out_pin_en_i(pen), .clock_out_pin_o(pin),
		.clock_out_pin_oe_o(pin_oe), .clock_irq_flag_o(flag));
	// ****************************************
	// Tasks and read monitor
	// ****************************************
	task chk(input [7:0] got, input [7:0] e);
	begin
		n_compared = n_compared + 1;
		if (got !== e)
		begin
			failures = failures + 1;
			$display("Error at %0t: got %h expected %h", $time, got, e);
		end
	end
	endtask
	// Strobes drop for a cycle so no signal is assigned twice in one step
	task wr(input [3:0] a, input [7:0] d);
	begin
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1;
		@(posedge clk_i);
		wr_i <= 0;
		@(posedge clk_i);
	end
	endtask
	task rd(input [3:0] a, input [7:0] e);
	begin
		exp_q.push_back(e);
		addr_i <= a;
		rd_i <= 1;
		@(posedge clk_i);
		rd_i <= 0;
		@(posedge clk_i);
	end
	endtask
	task pulse(input [3:0] v);
	begin
		adv <= v;
		@(posedge clk_i);
		adv <= 0;
		@(posedge clk_i);
	end
	endtask
	task rise;
	begin
		n = 0;
		do
		begin
			@(posedge clk_i);
			#1;
			n = n + 1;
		end
		while (!(pin === 1'b1 && pin_p === 1'b0) && n < 99);
	end
	endtask
	task wflag;
	begin
		n = 0;
		while (flag !== 1'b1 && n < 9000)
		begin
			@(posedge clk_i);
			n = n + 1;
		end
		if (n == 9000)
		begin
			failures = failures + 1;
			summarize;
		end
	end
	endtask
	task summarize;
	begin
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	always @(posedge clk_i)
	begin
		if (rd_q)
			chk(rdata, exp_q.pop_front());
		rd_q <= rd_i && ce;
		pin_p <= pin;
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1;
		@(posedge clk_i);
		rd(3, 8'h08);
		rd(1, 8'h00);
		wr(2, 8'hff);
		rd(2, 8'h3f);
		wr(4'hf, 8'hff);
		rd(4'hf, 8'h00);
		ce <= 0;
		repeat (3) @(posedge clk_i);
		ce <= 1;
		$display("test registers done");
		wr(1, 8'h80);
		for (i = 0; i < 4; i = i + 1)
		begin
			wr(2, 8'h00);
			pulse(4'h1 << i);
			rd(4, 8'h00);
			wr(2, 8'h01 << i);
			pulse(4'h1 << i);
			rd(4, 8'h01);
			wr(4, 8'h00);
			rd(4, 8'h00);
		end
		wr(2, 8'h10);
		dow <= 0;
		@(posedge clk_i);
		rd(4, 8'h01);
		wr(4, 8'h00);
		n = $random(seed);
		cal_s <= n[7:0];
		rd(0, n[7:0]);
		rd(0, n[7:0]);
		upd <= 1;
		@(posedge clk_i);
		upd <= 0;
		rd(5, 8'h80);
		repeat (25) @(posedge clk_i);
		rd(5, 8'h00);
		$display("test calendar done");
		wr(2, 8'h20);
		for (i = 0; i < 2; i = i + 1)
		begin
			p = i ? 8192 : 2048;
			wr(4, 8'h00);
			wr(3, i);
			wflag;
			wr(4, 8'h00);
			wflag;
			chk(n > p - 6 && n < p + 2, 8'h01);
		end
		wr(1, 8'h00);
		wr(4, 8'h00);
		repeat (3000) @(posedge clk_i);
		chk(flag, 8'h00);
		$display("test counter done");
		for (i = 0; i < 3; i = i + 1)
		begin
			wr(3, 8'h08 | (i << 5));
			rise;
			rise;
			chk(n, 8'h04 << i);
		end
		aos <= 0;
		repeat (20) @(posedge clk_i);
		chk(pin, 8'h00);
		aos <= 1;
		pen <= 0;
		repeat (2) @(posedge clk_i);
		chk(pin_oe, 8'h00);
		$display("test clock output done");
		repeat (3) @(posedge clk_i);
		summarize;
	end
endmodule
